// File: dv/apm_bus_master.sv
`timescale 1ns/1ps
// processor side of the module bus, one strobe per word access
module apm_bus_master (
	// clock
	input wire logic i_clk,
	// request out
	output apm_pkg::apm_bus_req_t o_bus,
	// answer in
	input wire logic [apm_pkg::DATA_W-1:0] i_rdata,
	input wire logic i_ack
);
	// idle bus from time zero
	initial o_bus = '0;

	// one word access; waits counts cycles after the first answer cycle
	// independent word cycles
	task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wdata,
		input logic [1:0] be, output logic [15:0] rdata, output int waits);
		@(posedge i_clk);
		// field order of the request: addr, wdata, be, wr, rd
		o_bus <= {addr, wdata, be, wr, !wr};
		@(posedge i_clk);
		o_bus <= '0;
		#1;
		// data stands only in this cycle, so take it now
		rdata = i_rdata;
		waits = 0;
		// bounded: a stuck ack must not hang the run
		while (i_ack !== 1'b1 && waits < 9) begin
			@(posedge i_clk);
			#1;
			waits++;
		end
	endtask : access
endmodule : apm_bus_master

// File: dv/apm_port_mux_bus_bench.sv
`timescale 1ns/1ps
module apm_port_mux_bus_bench;
	// clock, reset and bus
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	apm_pkg::apm_bus_req_t bus;
	logic conflict = 1'b0;
	logic [15:0] rdata;
	logic ack;
	// pins and queue engine side
	logic [7:0] pin_out, pin_oe;
	logic [7:0] ext_pins = 8'h00;
	logic [7:0] in_pins = 8'h00;
	logic [1:0] trig = 2'h0;
	logic [1:0] trig_mode = 2'h0;
	logic [1:0] trig_en, trig_lvl;
	logic ccw_v = 1'b0;
	logic [5:0] ccw_ch = 6'h00;
	logic [3:0] pin_sel;
	logic mux_mode;
	// bookkeeping
	int n_fail = 0;
	int check_count = 0;
	logic [15:0] rd;
	int w;

	// 100 MHz clock
	always #5 i_clk = ~i_clk;

	// wire level: the module's drive wins where it is enabled
	wire logic [7:0] pin_wire = (pin_out & pin_oe) | (ext_pins & ~pin_oe);

	apm_bus_master i_apm_bus_master (.i_clk(i_clk), .o_bus(bus), .i_rdata(rdata), .i_ack(ack));

	apm_port_mux_bus i_apm_port_mux_bus (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(bus),
		.i_engine_conflict(conflict), .o_bus_rdata(rdata), .o_bus_ack(ack),
		.i_bidir_port_pins(pin_wire), .o_bidir_port_pins_out(pin_out),
		.o_bidir_port_pins_oe(pin_oe), .i_input_port_pins(in_pins),
		.i_external_trigger_in(trig), .i_queue_ext_trig_mode(trig_mode),
		.o_trigger_in_en(trig_en), .o_trigger_level(trig_lvl), .i_ccw_valid(ccw_v),
		.i_ccw_channel(ccw_ch), .o_conv_pin_sel(pin_sel), .o_mux_mode(mux_mode));

	// compare of design values
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// compare of counted wait cycles
	task automatic chk_wait(input string name, input int exp, input int got);
		check_count++;
		if (got != exp) begin
			n_fail++;
			$display("FAIL %s expected %0d seen %0d", name, exp, got);
		end
	endtask : chk_wait

	// verdict and end of run
	task automatic finish_test();
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	// one bus access; a lost ack ends the run
	task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d,
		input logic [1:0] be);
		i_apm_bus_master.access(wr, a, d, be, rd, w);
		if (w > 8) begin
			n_fail++;
			finish_test();
		end
	endtask : acc

	// let n edges pass, then look after they land
	task automatic settle(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : settle

	// one command word pulse, result visible after the capture edge
	task automatic conversion_command_word(input logic [5:0] ch);
		@(posedge i_clk);
		ccw_v <= 1'b1;
		ccw_ch <= ch;
		@(posedge i_clk);
		ccw_v <= 1'b0;
		settle(1);
	endtask : conversion_command_word

	task automatic t_reset();
		acc(1'b0, apm_pkg::OFF_BIDIR_DIR, 16'h0000, 2'h3);
		chk("dir reset", 16'h0000, rd);
		chk("oe reset", 16'h0000, {8'h00, pin_oe});
	endtask : t_reset

	task automatic t_gpio();
		@(posedge i_clk);
		ext_pins <= 8'h3c;
		in_pins <= 8'h5a;
		acc(1'b1, apm_pkg::OFF_BIDIR_DIR, 16'h00f0, 2'h1);
		// low lane is read-only, so the ff must not land anywhere
		acc(1'b1, apm_pkg::OFF_PORT_DATA, 16'ha5ff, 2'h3);
		settle(4);
		chk("oe", 16'h00f0, {8'h00, pin_oe});
		chk("drive", 16'h00a0, {8'h00, pin_out & pin_oe});
		// odd address reaches the same word
		acc(1'b0, apm_pkg::OFF_PORT_DATA + 8'h01, 16'h0000, 2'h3);
		chk("port read", 16'hac5a, rd);
		// byte write at the odd address reaches the high lane only
		acc(1'b1, apm_pkg::OFF_PORT_DATA + 8'h01, 16'h3c00, 2'h2);
		settle(2);
		chk("odd byte", 16'h0030, {8'h00, pin_out & pin_oe});
	endtask : t_gpio

	task automatic t_mux();
		logic [5:0] chs [4] = '{6'h04, 6'h0d, 6'h16, 6'h1f};
		acc(1'b1, apm_pkg::OFF_CONTROL_ZERO, 16'h0080, 2'h1);
		acc(1'b0, apm_pkg::OFF_CONTROL_ZERO, 16'h0000, 2'h3);
		chk("cz read", 16'h0080, rd);
		// one channel from each of the four groups
		foreach (chs[i]) begin
			conversion_command_word(chs[i]);
			chk("group", {14'h0, chs[i][4], chs[i][0]}, {12'h000, pin_sel});
			chk("mux addr", {13'h0, chs[i][3:1]}, {13'h0, pin_out[2:0]});
			chk("mux oe", 16'h00f7, {8'h00, pin_oe});
			acc(1'b0, apm_pkg::OFF_PORT_DATA, 16'h0000, 2'h3);
			chk("latch read", {13'h0, chs[i][3:1]}, {13'h0, rd[10:8]});
		end
		chk("mux mode", 16'h0001, {15'h0, mux_mode});
	endtask : t_mux

	task automatic t_direct();
		acc(1'b1, apm_pkg::OFF_CONTROL_ZERO, 16'h0000, 2'h1);
		conversion_command_word(6'h09);
		chk("direct sel", 16'h0009, {12'h000, pin_sel});
		chk("gpio oe", 16'h00f0, {8'h00, pin_oe});
	endtask : t_direct

	task automatic t_trig();
		@(posedge i_clk);
		trig <= 2'h3;
		trig_mode <= 2'h1;
		settle(4);
		chk("trig en", 16'h0001, {14'h0, trig_en});
		chk("trig lvl", 16'h0001, {14'h0, trig_lvl});
		// status: latch kept from the last mux command, both triggers high
		acc(1'b0, apm_pkg::OFF_STATUS, 16'h0000, 2'h3);
		chk("status", 16'h0037, rd);
	endtask : t_trig

	task automatic t_wait();
		acc(1'b1, apm_pkg::OFF_BIDIR_DIR, 16'h0000, 2'h1);
		chk_wait("plain ack", 0, w);
		@(posedge i_clk);
		conflict <= 1'b1;
		acc(1'b1, apm_pkg::OFF_BIDIR_DIR, 16'h0000, 2'h1);
		chk_wait("held ack", 4, w);
		@(posedge i_clk);
		conflict <= 1'b0;
	endtask : t_wait

	// main sequence
	initial begin
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_reset();
		t_gpio();
		t_mux();
		t_direct();
		t_trig();
		t_wait();
		finish_test();
	end
endmodule : apm_port_mux_bus_bench

// File: logic/apm_pkg.sv
package apm_pkg;
	// port and address widths
	localparam int PORT_W = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int MUX_ADDR_W = 3;
	localparam int CHAN_W = 6;
	localparam int TRIG_N = 2;
	localparam int PIN_SEL_W = 4;
	// most wait states that one conflicting access may add
	localparam logic [2:0] MAX_WAIT = 3'h4;

	// register byte addresses, each a 16-bit word
	localparam logic [ADDR_W-1:0] OFF_CONTROL_ZERO = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_BIDIR_DIR = 8'h02;
	localparam logic [ADDR_W-1:0] OFF_PORT_DATA = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h06;

	// field positions
	localparam int CZ_MUX_BIT = 7;
	localparam int ST_TRIG_LSB = 4;
	localparam int ST_BUSY_BIT = 6;

	// reset values
	localparam logic [PORT_W-1:0] DIR_RST = 8'h00;
	localparam logic [PORT_W-1:0] DATA_RST = 8'h00;

	// register bus request, one cycle per strobe
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0] be;
		logic wr;
		logic rd;
	} apm_bus_req_t;

	// bidirectional pin drive pair
	typedef struct packed {
		logic [PORT_W-1:0] out;
		logic [PORT_W-1:0] oe;
	} apm_pin_drive_t;
endpackage : apm_pkg

// File: logic/apm_port_mux_bus.sv
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - each bidir pin direction set per bit
// - input bits read pin, outputs drive latch
// - port reads show input pins and output latch bits
// - input-only port, no direction, all pins read
// - two triggers, input when queue externally triggered
// - three-bit address drives external multiplexers
// - mux mode forces address pins to outputs
// - address pins are gpio outside mux mode
// - four input pins map eight channels each
// - direct mode routes sixteen pins internally
// - byte, half and word transfers, any alignment
// - wide accesses are independent cycles, incoherent
// - plain access completes in two cycles
// - conflicting access adds one to four waits
// - control zero mux bit overrides low directions
// - direction one is output, zero input
// - mux mode reads address latch on low bits
module apm_port_mux_bus #(
	parameter int PORT_W = apm_pkg::PORT_W
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// register bus
	input wire apm_pkg::apm_bus_req_t i_bus,
	input wire logic i_engine_conflict,
	output logic [apm_pkg::DATA_W-1:0] o_bus_rdata,
	output logic o_bus_ack,
	// bidirectional port
	input wire logic [PORT_W-1:0] i_bidir_port_pins,
	output logic [PORT_W-1:0] o_bidir_port_pins_out,
	output logic [PORT_W-1:0] o_bidir_port_pins_oe,
	// input-only port
	input wire logic [PORT_W-1:0] i_input_port_pins,
	// external triggers
	input wire logic [apm_pkg::TRIG_N-1:0] i_external_trigger_in,
	input wire logic [apm_pkg::TRIG_N-1:0] i_queue_ext_trig_mode,
	output logic [apm_pkg::TRIG_N-1:0] o_trigger_in_en,
	output logic [apm_pkg::TRIG_N-1:0] o_trigger_level,
	// conversion command word from the queue engine
	input wire logic i_ccw_valid,
	input wire logic [apm_pkg::CHAN_W-1:0] i_ccw_channel,
	output logic [apm_pkg::PIN_SEL_W-1:0] o_conv_pin_sel,
	output logic o_mux_mode
);
	localparam int SYNC_W = 2 * PORT_W + apm_pkg::TRIG_N;
	localparam int MA_W = apm_pkg::MUX_ADDR_W;

	// software state
	logic mux_en_q; // externally multiplexed mode
	logic [PORT_W-1:0] dir_q; // direction, one means output
	logic [PORT_W-1:0] data_q; // output latch of the bidir port
	logic [MA_W-1:0] mux_addr_q; // multiplexer address latch
	// synchronised pin levels
	logic [SYNC_W-1:0] sync_all;
	logic [PORT_W-1:0] bidir_sync;
	logic [PORT_W-1:0] input_sync;
	logic [apm_pkg::TRIG_N-1:0] trig_sync;
	// bus decode
	logic [apm_pkg::ADDR_W-1:0] word_addr;
	logic hit_cz, hit_dir, hit_data, hit_st;
	logic [apm_pkg::DATA_W-1:0] rd_val;
	logic [PORT_W-1:0] bidir_view;
	// wait-state tracking
	logic pend_q;
	logic [2:0] wait_q;
	// next pin drive
	apm_pkg::apm_pin_drive_t drive_d;

	// two-stage synchroniser on every digital input
	// costs two cycles of read latency but keeps metastable levels out of the decode
	apm_sync #(
		.W(SYNC_W)
	) i_apm_sync (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async({i_external_trigger_in, i_input_port_pins, i_bidir_port_pins}),
		.o_sync(sync_all)
	);

	// split the synchronised bundle
	assign bidir_sync = sync_all[PORT_W-1:0];
	assign input_sync = sync_all[2*PORT_W-1:PORT_W];
	assign trig_sync = sync_all[SYNC_W-1:2*PORT_W];

	// address bit zero is dropped, odd addresses reach the same word; the byte enables pick the lane
	assign word_addr = {i_bus.addr[apm_pkg::ADDR_W-1:1], 1'b0};
	assign hit_cz = (word_addr == apm_pkg::OFF_CONTROL_ZERO);
	assign hit_dir = (word_addr == apm_pkg::OFF_BIDIR_DIR);
	assign hit_data = (word_addr == apm_pkg::OFF_PORT_DATA);
	assign hit_st = (word_addr == apm_pkg::OFF_STATUS);

	// control zero: only the mux enable is kept
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mux_en_q <= 1'b0;
		end else if (i_bus.wr && hit_cz && i_bus.be[0]) begin
			// mux mode enabled from control zero
			mux_en_q <= i_bus.wdata[apm_pkg::CZ_MUX_BIT];
		end
	end

	// direction register, low lane only
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			dir_q <= apm_pkg::DIR_RST;
		end else if (i_bus.wr && hit_dir && i_bus.be[0]) begin
			dir_q <= i_bus.wdata[PORT_W-1:0];
		end
	end

	// bidir output latch sits in the high lane of the data word
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			data_q <= apm_pkg::DATA_RST;
		end else if (i_bus.wr && hit_data && i_bus.be[1]) begin
			data_q <= i_bus.wdata[apm_pkg::DATA_W-1:PORT_W];
		end
	end

	// address latch and channel routing, taken per command word
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mux_addr_q <= '0;
			o_conv_pin_sel <= '0;
		end else if (i_ccw_valid) begin
			if (mux_en_q) begin
				// address bits select one of eight inputs
				mux_addr_q <= i_ccw_channel[MA_W:1];
				// even low, odd low, even high, odd high groups
				o_conv_pin_sel <= {2'b00, i_ccw_channel[4], i_ccw_channel[0]};
			end else begin
				o_conv_pin_sel <= i_ccw_channel[apm_pkg::PIN_SEL_W-1:0];
			end
		end
	end

	// next pin drive, mux mode overrides the three low pins
	always_comb begin
		// outputs drive the latch, one means output
		drive_d.out = data_q;
		drive_d.oe = dir_q;
		if (mux_en_q) begin
			// address pins forced out from the latch
			drive_d.out[MA_W-1:0] = mux_addr_q;
			drive_d.oe[MA_W-1:0] = {MA_W{1'b1}};
		end
		// otherwise the low pins keep their gpio settings
	end

	// registered pin drive
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_bidir_port_pins_out <= '0;
			o_bidir_port_pins_oe <= '0;
			o_mux_mode <= 1'b0;
		end else begin
			o_bidir_port_pins_out <= drive_d.out;
			o_bidir_port_pins_oe <= drive_d.oe;
			o_mux_mode <= mux_en_q;
		end
	end

	// trigger pin is a digital input in external trigger mode
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_trigger_in_en <= '0;
			o_trigger_level <= '0;
		end else begin
			o_trigger_in_en <= i_queue_ext_trig_mode;
			o_trigger_level <= trig_sync & i_queue_ext_trig_mode;
		end
	end

	// read view of the bidir port
	always_comb begin
		// every pin is captured, outputs show their latch
		bidir_view = (bidir_sync & ~dir_q) | (data_q & dir_q);
		if (mux_en_q) begin
			// low bits read the address latch
			bidir_view[MA_W-1:0] = mux_addr_q;
		end
	end

	// read mux, unmapped addresses read zero
	always_comb begin
		rd_val = '0;
		if (hit_cz) begin
			rd_val[apm_pkg::CZ_MUX_BIT] = mux_en_q;
		end else if (hit_dir) begin
			rd_val[PORT_W-1:0] = dir_q;
		end else if (hit_data) begin
			// input port has no direction, all pins read
			rd_val = {bidir_view, input_sync};
		end else if (hit_st) begin
			rd_val[MA_W-1:0] = mux_addr_q;
			rd_val[apm_pkg::ST_TRIG_LSB+:apm_pkg::TRIG_N] = trig_sync;
			rd_val[apm_pkg::ST_BUSY_BIT] = pend_q;
		end
	end

	// no holding register: each half stands alone
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_bus_rdata <= '0;
		end else if (i_bus.rd) begin
			o_bus_rdata <= rd_val;
		end else begin
			o_bus_rdata <= '0;
		end
	end

	// access completion; a new strobe restarts the tracking
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pend_q <= 1'b0;
			wait_q <= '0;
			o_bus_ack <= 1'b0;
		end else if (i_bus.rd || i_bus.wr) begin
			// plain access acknowledged in its second cycle
			o_bus_ack <= !i_engine_conflict;
			pend_q <= i_engine_conflict;
			wait_q <= 3'h1;
		end else if (pend_q) begin
			// stretch while the engine holds the location
			if (i_engine_conflict && wait_q < apm_pkg::MAX_WAIT) begin
				wait_q <= wait_q + 3'h1;
				o_bus_ack <= 1'b0;
			end else begin
				pend_q <= 1'b0;
				o_bus_ack <= 1'b1;
			end
		end else begin
			o_bus_ack <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	a_dir_drives_oe: assert property (
		##1 o_bidir_port_pins_oe[PORT_W-1:MA_W] == $past(dir_q[PORT_W-1:MA_W])
	) else $error("upper pin enables do not follow direction");

	a_mux_forces_out: assert property (
		mux_en_q |=> o_bidir_port_pins_oe[MA_W-1:0] == 3'h7
			&& o_bidir_port_pins_out[MA_W-1:0] == $past(mux_addr_q)
	) else $error("address pins not forced in mux mode");

	a_gpio_low_pins: assert property (
		!mux_en_q |=> o_bidir_port_pins_oe[MA_W-1:0] == $past(dir_q[MA_W-1:0])
			&& o_bidir_port_pins_out[MA_W-1:0] == $past(data_q[MA_W-1:0])
	) else $error("low pins not gpio outside mux mode");

	a_dir_readback: assert property (
		i_bus.rd && hit_dir |=> o_bus_rdata == {8'h00, $past(dir_q)}
	) else $error("direction read mismatch");

	a_input_port_read: assert property (
		i_bus.rd && hit_data |=> o_bus_rdata[PORT_W-1:0] == $past(input_sync)
	) else $error("input port read mismatch");

	a_addr_latch_read: assert property (
		i_bus.rd && hit_data && mux_en_q |=> o_bus_rdata[PORT_W+MA_W-1:PORT_W] == $past(mux_addr_q)
	) else $error("mux latch not read in mux mode");

	a_plain_two_cycle: assert property (
		(i_bus.rd || i_bus.wr) && !i_engine_conflict |=> o_bus_ack
	) else $error("plain access not done in two cycles");

	a_wait_bound: assert property (
		(i_bus.rd || i_bus.wr) && i_engine_conflict |=> !o_bus_ack
	) else $error("conflicting access got no wait state");

	a_wait_range: assert property (
		(i_bus.rd || i_bus.wr) && i_engine_conflict ##1 !(i_bus.rd || i_bus.wr)
			|-> !o_bus_ack ##[1:4] o_bus_ack
	) else $error("conflicting access waits outside one to four");

	a_trig_enable: assert property (
		##1 o_trigger_in_en == $past(i_queue_ext_trig_mode)
	) else $error("trigger input enable wrong");

	a_group_map: assert property (
		i_ccw_valid && mux_en_q |=> mux_addr_q == $past(i_ccw_channel[MA_W:1])
			&& o_conv_pin_sel == {2'b00, $past(i_ccw_channel[4]), $past(i_ccw_channel[0])}
	) else $error("multiplexed channel mapping wrong");

	a_direct_map: assert property (
		i_ccw_valid && !mux_en_q |=> o_conv_pin_sel == $past(i_ccw_channel[3:0])
	) else $error("direct channel routing wrong");

	// reads of control zero return the stored mux enable
	a_cz_readback: assert property (
		i_bus.rd && hit_cz |=> o_bus_rdata[apm_pkg::CZ_MUX_BIT] == $past(mux_en_q)
	) else $error("control zero read mismatch");

	// status shows the address latch and the synchronised triggers
	a_status_read: assert property (
		i_bus.rd && hit_st |=> o_bus_rdata[MA_W-1:0] == $past(mux_addr_q)
			&& o_bus_rdata[apm_pkg::ST_TRIG_LSB+:apm_pkg::TRIG_N] == $past(trig_sync)
	) else $error("status read mismatch");

	// read data stand only in the cycle after a read strobe
	a_rdata_idle: assert property (
		!i_bus.rd |=> o_bus_rdata == '0
	) else $error("read data outside their cycle");

	// a completion is a single pulse unless a new strobe follows
	a_ack_pulse: assert property (
		o_bus_ack && !(i_bus.rd || i_bus.wr) |=> !o_bus_ack
	) else $error("ack longer than one cycle");

	// trigger level follows the synchronised pin only when enabled
	a_trig_level: assert property (
		##1 o_trigger_level == $past(trig_sync & i_queue_ext_trig_mode)
	) else $error("trigger level wrong");

	// input bits read the pin, output bits the latch
	a_bidir_read: assert property (
		i_bus.rd && hit_data && !mux_en_q |=> o_bus_rdata[apm_pkg::DATA_W-1:PORT_W]
			== $past((bidir_sync & ~dir_q) | (data_q & dir_q))
	) else $error("bidir port read mismatch");

	// the output latch takes the high lane only
	a_latch_write: assert property (
		i_bus.wr && hit_data && i_bus.be[1]
			|=> data_q == $past(i_bus.wdata[apm_pkg::DATA_W-1:PORT_W])
	) else $error("output latch write lost");

	// main scenarios, each seen at least once
	c_plain_read: cover property (i_bus.rd && !i_engine_conflict ##1 o_bus_ack);
	c_direct_command: cover property (!mux_en_q && i_ccw_valid);
	c_four_waits: cover property (pend_q && wait_q == apm_pkg::MAX_WAIT ##1 o_bus_ack);
	c_mux_command: cover property (mux_en_q && i_ccw_valid);
	c_odd_byte_write: cover property (i_bus.wr && i_bus.addr[0] && i_bus.be == 2'b10);
endmodule : apm_port_mux_bus

// File: logic/apm_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser for a bundle of level signals
module apm_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	// first stage is read by the second stage only
	logic [W-1:0] meta_q;

	// two-stage capture, cleared on reset
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule : apm_sync
